// ===== pkg/ats_defs.svh
// register offsets, field positions, reset values and timing for the trigger sequencer
`ifndef ATS_DEFS_SVH
`define ATS_DEFS_SVH
// ----------------------------------------
// register offsets (byte addresses)
// ----------------------------------------
`define ATS_REG_CTRL 8'h00
`define ATS_REG_CFG 8'h04
`define ATS_REG_MSCAN 8'h08
`define ATS_REG_CHLEN 8'h0c
`define ATS_REG_POSTCNT 8'h10
`define ATS_REG_TSCAN 8'h14
`define ATS_REG_THRESH 8'h18
`define ATS_REG_STATUS 8'h1c
// ----------------------------------------
// field positions
// ----------------------------------------
`define ATS_CTRL_START 0
`define ATS_CTRL_STOP 1
`define ATS_CFG_SRC 0
`define ATS_CFG_FLOW 4
`define ATS_CFG_TSCAN 8
`define ATS_CFG_RTEXT 9
`define ATS_CFG_THRCH 10
`define ATS_STAT_CHAN 16
// ----------------------------------------
// reset values and responses
// ----------------------------------------
`define ATS_RST_ZERO 32'h0000_0000
`define ATS_RESP_OKAY 2'h0
`define ATS_RESP_SLVERR 2'h2
// ----------------------------------------
// timing and analog scaling
// ----------------------------------------
`define ATS_SYS_HZ 100000000
`define ATS_TSC_HZ 20000000
`define ATS_TSC_DIV (`ATS_SYS_HZ / `ATS_TSC_HZ)
`define ATS_HYST_MV 50
`define ATS_SPAN_MV 20000
`define ATS_CODE_SPAN 65536
`define ATS_HYST_CODE ((`ATS_HYST_MV * `ATS_CODE_SPAN) / `ATS_SPAN_MV)
`endif

// ===== pkg/ats_pkg.sv
// types shared by the trigger sequencer modules
`default_nettype none
package ats_pkg;
  typedef enum logic [2:0] {
    ATS_SRC_SW = 3'h0,
    ATS_SRC_DIG_RISE = 3'h1,
    ATS_SRC_DIG_FALL = 3'h2,
    ATS_SRC_THR_RISE = 3'h3,
    ATS_SRC_THR_FALL = 3'h4
  } ats_src_e;
  typedef enum logic [1:0] {
    ATS_FLOW_POST = 2'h0,
    ATS_FLOW_PRE = 2'h1,
    ATS_FLOW_ABOUT = 2'h2
  } ats_flow_e;
  typedef enum logic [3:0] {
    ATS_ST_IDLE = 4'h1,
    ATS_ST_WAIT = 4'h2,
    ATS_ST_ACQ = 4'h4,
    ATS_ST_RETRIG = 4'h8
  } ats_state_e;
  typedef struct packed {
    logic thr_chan;
    logic retrig_ext;
    logic tscan_en;
    ats_flow_e flow;
    ats_src_e src;
  } ats_cfg_s;
  typedef struct packed {
    logic sw;
    logic dig_rise;
    logic dig_fall;
    logic thr_rise;
    logic thr_fall;
  } ats_evt_s;
endpackage
`default_nettype wire

// ===== src/ats_edge_sync.sv
// two-stage synchroniser with single-pulse edge detection for a pin
`timescale 1ns/1ps
`default_nettype none
module ats_edge_sync (
  input wire logic i_clk,
  input wire logic i_rst,
  input wire logic i_pin,
  output logic o_rise,
  output logic o_fall
);
  logic s1_q;
  logic s2_q;
  logic s3_q;

  // only s2_q and later stages feed logic
  always_ff @(posedge i_clk or posedge i_rst) begin
    if (i_rst) begin
      s1_q <= 1'b0;
      s2_q <= 1'b0;
      s3_q <= 1'b0;
    end else begin
      s1_q <= i_pin;
      s2_q <= s1_q;
      s3_q <= s2_q;
    end
  end

  always_ff @(posedge i_clk or posedge i_rst) begin
    if (i_rst) begin
      o_rise <= 1'b0;
      o_fall <= 1'b0;
    end else begin
      o_rise <= s2_q & ~s3_q;
      o_fall <= ~s2_q & s3_q;
    end
  end

  a_edge_one_pulse: assert property (@(posedge i_clk) disable iff (i_rst) o_rise |=> !o_rise)
    else $error("edge pulse lasted more than one cycle");
endmodule
`default_nettype wire

// ===== src/ats_threshold.sv
// threshold comparator with fixed hysteresis on a selectable analog code
`timescale 1ns/1ps
`default_nettype none
`include "ats_defs.svh"
module ats_threshold (
  input wire logic i_clk,
  input wire logic i_rst,
  input wire logic [15:0] i_ext_code,
  input wire logic [15:0] i_chan_code,
  input wire logic i_sel_chan,
  input wire logic [7:0] i_level,
  output logic o_rise,
  output logic o_fall
);
  logic [15:0] e1_q;
  logic [15:0] e2_q;
  logic [15:0] c1_q;
  logic [15:0] c2_q;
  logic [15:0] e3_q;
  logic [15:0] c3_q;
  logic [15:0] hold_q;
  logic above_q;
  logic [16:0] code;
  logic [16:0] lvl;
  logic [16:0] hi;

  // codes come from converters on their own timing, so both are synchronised
  always_ff @(posedge i_clk or posedge i_rst) begin
    if (i_rst) begin
      e1_q <= '0;
      e2_q <= '0;
      e3_q <= '0;
      c1_q <= '0;
      c2_q <= '0;
      c3_q <= '0;
    end else begin
      e1_q <= i_ext_code;
      e2_q <= e1_q;
      e3_q <= e2_q;
      c1_q <= i_chan_code;
      c2_q <= c1_q;
      c3_q <= c2_q;
    end
  end

  // a word caught mid-change can mix old and new bits; take it only once two samples agree
  always_ff @(posedge i_clk or posedge i_rst) begin
    if (i_rst) begin
      hold_q <= '0;
    end else if (i_sel_chan ? (c2_q == c3_q) : (e2_q == e3_q)) begin
      hold_q <= i_sel_chan ? c2_q : e2_q;
    end
  end

  assign code = {1'b0, hold_q};
  assign lvl = {1'b0, i_level, 8'h00};
  assign hi = lvl + 17'(`ATS_HYST_CODE);

  always_ff @(posedge i_clk or posedge i_rst) begin
    if (i_rst) begin
      above_q <= 1'b0;
      o_rise <= 1'b0;
      o_fall <= 1'b0;
    end else begin
      o_rise <= 1'b0;
      o_fall <= 1'b0;
      if (!above_q && code >= hi) begin
        above_q <= 1'b1;
        o_rise <= 1'b1;
      end else if (above_q && code < lvl) begin
        above_q <= 1'b0;
        o_fall <= 1'b1;
      end
    end
  end

  a_thr_rise_cause: assert property (@(posedge i_clk) disable iff (i_rst) o_rise |-> above_q && !$past(above_q))
    else $error("rising threshold event without a crossing");
endmodule
`default_nettype wire

// ===== src/ats_sequencer.sv
// trigger and acquisition-mode sequencer with its register slave
//
// Summary of operation
// - start write is the software trigger
// - external edge polarity is selectable
// - threshold crossings give rising or falling events
// - threshold input: external or amplified channel
// - threshold level is an 8-bit code
// - threshold hysteresis is fixed at 50 mV
// - post, pre and about modes are supported
// - post mode accepts any start source
// - post run ends at count or stop
// - triggered scan keeps acquiring on retriggers
// - without triggered scan, channel list loops until the run ends
// - burst of multiscan passes, then wait retrigger
// - pre run ends at post event, sample discarded
// - pre bursts paced by scan counter until event
// - trigger-out high while waiting for trigger
// - scan counter is 24 bits at 20 MHz
// - multiscan count reaches 256 passes
// - retrigger edges during a burst are ignored
`timescale 1ns/1ps
`default_nettype none
`include "ats_defs.svh"
module ats_sequencer #(
  parameter int ADDR_W = 8,
  parameter int CHAN_W = 10,
  parameter int CNT_W = 24,
  parameter int TSC_W = 24
) (
  input wire logic I_SYS_CLK,
  input wire logic I_RST,
  input wire logic I_AWVALID,
  output logic O_AWREADY,
  input wire logic [ADDR_W-1:0] I_AWADDR,
  input wire logic I_WVALID,
  output logic O_WREADY,
  input wire logic [31:0] I_WDATA,
  input wire logic [3:0] I_WSTRB,
  output logic O_BVALID,
  input wire logic I_BREADY,
  output logic [1:0] O_BRESP,
  input wire logic I_ARVALID,
  output logic O_ARREADY,
  input wire logic [ADDR_W-1:0] I_ARADDR,
  output logic O_RVALID,
  input wire logic I_RREADY,
  output logic [31:0] O_RDATA,
  output logic [1:0] O_RRESP,
  input wire logic I_EXT_TRIG,
  input wire logic I_SAMPLE_CLK,
  input wire logic [15:0] I_EXT_ANALOG,
  input wire logic [15:0] I_CHAN_ANALOG,
  output logic [7:0] O_THRESH_CODE,
  output logic O_TRIG_OUT,
  output logic O_CONVERT,
  output logic O_DISCARD,
  output logic O_PRETRIG,
  output logic [CHAN_W-1:0] O_CHAN_IDX,
  output logic O_ACTIVE
);
  import ats_pkg::*;

  localparam int DIV_W = $clog2(`ATS_TSC_DIV);

  if (ADDR_W < 5 || ADDR_W > 32 || CHAN_W < 1 || CHAN_W > 15 || CNT_W < 1 || CNT_W > 32
      || TSC_W < 1 || TSC_W > 32) begin : g_bad_param
    $error("ats_sequencer: parameter out of range");
  end

  // ----------------------------------------
  // register state
  // ----------------------------------------
  ats_cfg_s cfg_q;
  logic [7:0] mscan_q;
  logic [CHAN_W-1:0] chlen_q;
  logic [CNT_W-1:0] postcnt_q;
  logic [TSC_W-1:0] tscan_q;
  logic start_q;
  logic stop_q;
  logic [ADDR_W-1:0] aw_addr_q;
  logic [31:0] w_data_q;
  logic [3:0] w_strb_q;

  // ----------------------------------------
  // sequencer state
  // ----------------------------------------
  ats_state_e state_q;
  logic pretrig_q;
  logic [CHAN_W-1:0] chan_q;
  logic [7:0] pass_q;
  logic [CNT_W-1:0] post_n_q;
  logic [DIV_W-1:0] div_q;
  logic [TSC_W-1:0] tsc_q;

  ats_evt_s ev;
  logic samp;
  logic post_ev;
  logic retrig_ev;
  logic in_run;
  logic waiting;
  logic pre_end;
  logic take;
  logic last_ch;
  logic burst_end;
  logic cnt_done;
  logic use_tsc;
  logic tick;
  logic tsc_exp;
  logic do_wr;
  logic [31:0] wr_new;

  // ----------------------------------------
  // helpers
  // ----------------------------------------
  function automatic logic ats_hit(input ats_src_e src, input ats_evt_s e);
    case (src)
      ATS_SRC_SW: ats_hit = e.sw;
      ATS_SRC_DIG_RISE: ats_hit = e.dig_rise;
      ATS_SRC_DIG_FALL: ats_hit = e.dig_fall;
      ATS_SRC_THR_RISE: ats_hit = e.thr_rise;
      ATS_SRC_THR_FALL: ats_hit = e.thr_fall;
      default: ats_hit = 1'b0;
    endcase
  endfunction

  function automatic logic [31:0] ats_merge(input logic [31:0] old, input logic [31:0] data, input logic [3:0] strb);
    logic [31:0] r;
    r = old;
    for (int i = 0; i < 4; i++) begin
      if (strb[i]) begin
        r[8*i +: 8] = data[8*i +: 8];
      end
    end
    return r;
  endfunction

  function automatic logic ats_mapped(input logic [ADDR_W-1:0] a);
    return a <= ADDR_W'(`ATS_REG_STATUS) && a[1:0] == 2'h0;
  endfunction

  function automatic logic [31:0] ats_rmux(input logic [ADDR_W-1:0] a);
    case (a)
      ADDR_W'(`ATS_REG_CFG): ats_rmux = 32'({cfg_q.thr_chan, cfg_q.retrig_ext, cfg_q.tscan_en, 2'h0, cfg_q.flow,
                                            1'b0, cfg_q.src});
      ADDR_W'(`ATS_REG_MSCAN): ats_rmux = 32'(mscan_q);
      ADDR_W'(`ATS_REG_CHLEN): ats_rmux = 32'(chlen_q);
      ADDR_W'(`ATS_REG_POSTCNT): ats_rmux = 32'(postcnt_q);
      ADDR_W'(`ATS_REG_TSCAN): ats_rmux = 32'(tscan_q);
      ADDR_W'(`ATS_REG_THRESH): ats_rmux = 32'(O_THRESH_CODE);
      ADDR_W'(`ATS_REG_STATUS): ats_rmux = 32'({chan_q, 10'h000, O_TRIG_OUT, pretrig_q, state_q});
      default: ats_rmux = `ATS_RST_ZERO;
    endcase
  endfunction

  // ----------------------------------------
  // register bus: write channel
  // ----------------------------------------
  assign do_wr = !O_AWREADY && !O_WREADY && !O_BVALID;
  assign wr_new = ats_merge(ats_rmux(aw_addr_q), w_data_q, w_strb_q);

  always_ff @(posedge I_SYS_CLK or posedge I_RST) begin
    if (I_RST) begin
      O_AWREADY <= 1'b1;
      O_WREADY <= 1'b1;
      O_BVALID <= 1'b0;
      O_BRESP <= `ATS_RESP_OKAY;
      aw_addr_q <= '0;
      w_data_q <= '0;
      w_strb_q <= '0;
    end else begin
      if (I_AWVALID && O_AWREADY) begin
        aw_addr_q <= I_AWADDR;
        O_AWREADY <= 1'b0;
      end
      if (I_WVALID && O_WREADY) begin
        w_data_q <= I_WDATA;
        w_strb_q <= I_WSTRB;
        O_WREADY <= 1'b0;
      end
      if (do_wr) begin
        O_BVALID <= 1'b1;
        O_BRESP <= ats_mapped(aw_addr_q) ? `ATS_RESP_OKAY : `ATS_RESP_SLVERR;
      end
      if (O_BVALID && I_BREADY) begin
        O_BVALID <= 1'b0;
        O_AWREADY <= 1'b1;
        O_WREADY <= 1'b1;
      end
    end
  end

  // control pulses take effect the cycle after the write commits
  always_ff @(posedge I_SYS_CLK or posedge I_RST) begin
    if (I_RST) begin
      start_q <= 1'b0;
      stop_q <= 1'b0;
    end else begin
      start_q <= do_wr && aw_addr_q == ADDR_W'(`ATS_REG_CTRL) && w_strb_q[0] && w_data_q[`ATS_CTRL_START];
      stop_q <= do_wr && aw_addr_q == ADDR_W'(`ATS_REG_CTRL) && w_strb_q[0] && w_data_q[`ATS_CTRL_STOP];
    end
  end

  always_ff @(posedge I_SYS_CLK or posedge I_RST) begin
    if (I_RST) begin
      cfg_q <= ats_cfg_s'(`ATS_RST_ZERO);
      mscan_q <= '0;
      chlen_q <= '0;
      postcnt_q <= '0;
      tscan_q <= '0;
      O_THRESH_CODE <= '0;
    end else if (do_wr) begin
      case (aw_addr_q)
        ADDR_W'(`ATS_REG_CFG): begin
          cfg_q.src <= ats_src_e'(wr_new[`ATS_CFG_SRC +: 3]);
          cfg_q.flow <= ats_flow_e'(wr_new[`ATS_CFG_FLOW +: 2]);
          cfg_q.tscan_en <= wr_new[`ATS_CFG_TSCAN];
          cfg_q.retrig_ext <= wr_new[`ATS_CFG_RTEXT];
          cfg_q.thr_chan <= wr_new[`ATS_CFG_THRCH];
        end
        ADDR_W'(`ATS_REG_MSCAN): mscan_q <= wr_new[7:0];
        ADDR_W'(`ATS_REG_CHLEN): chlen_q <= wr_new[CHAN_W-1:0];
        ADDR_W'(`ATS_REG_POSTCNT): postcnt_q <= wr_new[CNT_W-1:0];
        ADDR_W'(`ATS_REG_TSCAN): tscan_q <= wr_new[TSC_W-1:0];
        ADDR_W'(`ATS_REG_THRESH): O_THRESH_CODE <= wr_new[7:0];
        default: begin
        end
      endcase
    end
  end

  // ----------------------------------------
  // register bus: read channel
  // ----------------------------------------
  always_ff @(posedge I_SYS_CLK or posedge I_RST) begin
    if (I_RST) begin
      O_ARREADY <= 1'b1;
      O_RVALID <= 1'b0;
      O_RDATA <= `ATS_RST_ZERO;
      O_RRESP <= `ATS_RESP_OKAY;
    end else if (I_ARVALID && O_ARREADY) begin
      O_ARREADY <= 1'b0;
      O_RVALID <= 1'b1;
      O_RDATA <= ats_rmux(I_ARADDR);
      O_RRESP <= ats_mapped(I_ARADDR) ? `ATS_RESP_OKAY : `ATS_RESP_SLVERR;
    end else if (O_RVALID && I_RREADY) begin
      O_RVALID <= 1'b0;
      O_ARREADY <= 1'b1;
    end
  end

  // ----------------------------------------
  // event sources
  // ----------------------------------------
  ats_edge_sync u_ext_edge (
    .i_clk(I_SYS_CLK),
    .i_rst(I_RST),
    .i_pin(I_EXT_TRIG),
    .o_rise(ev.dig_rise),
    .o_fall(ev.dig_fall)
  );

  ats_edge_sync u_samp_edge (
    .i_clk(I_SYS_CLK),
    .i_rst(I_RST),
    .i_pin(I_SAMPLE_CLK),
    .o_rise(samp),
    .o_fall()
  );

  ats_threshold u_thr (
    .i_clk(I_SYS_CLK),
    .i_rst(I_RST),
    .i_ext_code(I_EXT_ANALOG),
    .i_chan_code(I_CHAN_ANALOG),
    .i_sel_chan(cfg_q.thr_chan),
    .i_level(O_THRESH_CODE),
    .o_rise(ev.thr_rise),
    .o_fall(ev.thr_fall)
  );

  assign ev.sw = start_q;
  assign post_ev = ats_hit(cfg_q.src, ev);
  assign in_run = state_q == ATS_ST_ACQ || state_q == ATS_ST_RETRIG;
  assign waiting = state_q == ATS_ST_WAIT || state_q == ATS_ST_RETRIG;
  assign pre_end = cfg_q.flow == ATS_FLOW_PRE && post_ev && in_run;
  assign take = state_q == ATS_ST_ACQ && samp && !pre_end;
  assign last_ch = chan_q == chlen_q;
  assign burst_end = take && last_ch && cfg_q.tscan_en && pass_q == mscan_q;
  assign cnt_done = take && !pretrig_q && postcnt_q != '0 && post_n_q == postcnt_q - CNT_W'(1);
  // pre and about runs never take an external retrigger
  assign use_tsc = cfg_q.tscan_en && (cfg_q.flow != ATS_FLOW_POST || !cfg_q.retrig_ext);
  assign retrig_ev = use_tsc ? tsc_exp : (cfg_q.retrig_ext && ats_hit(cfg_q.src, ev));

  // ----------------------------------------
  // state machine
  // ----------------------------------------
  always_ff @(posedge I_SYS_CLK or posedge I_RST) begin
    if (I_RST) begin
      state_q <= ATS_ST_IDLE;
    end else if (stop_q) begin
      state_q <= ATS_ST_IDLE;
    end else begin
      case (state_q)
        ATS_ST_IDLE: begin
          if (start_q) begin
            state_q <= (cfg_q.flow == ATS_FLOW_POST && cfg_q.src != ATS_SRC_SW) ? ATS_ST_WAIT : ATS_ST_ACQ;
          end
        end
        ATS_ST_WAIT: begin
          if (post_ev) begin
            state_q <= ATS_ST_ACQ;
          end
        end
        ATS_ST_ACQ: begin
          if (pre_end || cnt_done) begin
            state_q <= ATS_ST_IDLE;
          end else if (burst_end) begin
            state_q <= ATS_ST_RETRIG;
          end
        end
        ATS_ST_RETRIG: begin
          if (pre_end) begin
            state_q <= ATS_ST_IDLE;
          end else if (retrig_ev) begin
            state_q <= ATS_ST_ACQ;
          end
        end
        default: state_q <= ATS_ST_IDLE;
      endcase
    end
  end

  // pre-trigger phase flag; about mode switches to post data at the event
  always_ff @(posedge I_SYS_CLK or posedge I_RST) begin
    if (I_RST) begin
      pretrig_q <= 1'b0;
    end else if (state_q == ATS_ST_IDLE) begin
      pretrig_q <= start_q && cfg_q.flow != ATS_FLOW_POST;
    end else if (cfg_q.flow == ATS_FLOW_ABOUT && post_ev && in_run) begin
      pretrig_q <= 1'b0;
    end
  end

  // ----------------------------------------
  // channel list and pass counting
  // ----------------------------------------
  always_ff @(posedge I_SYS_CLK or posedge I_RST) begin
    if (I_RST) begin
      chan_q <= '0;
      pass_q <= '0;
    end else if (state_q != ATS_ST_ACQ) begin
      chan_q <= '0;
      pass_q <= '0;
    end else if (take) begin
      if (last_ch) begin
        chan_q <= '0;
        pass_q <= burst_end ? 8'h00 : pass_q + 8'h01;
      end else begin
        chan_q <= chan_q + CHAN_W'(1);
      end
    end
  end

  always_ff @(posedge I_SYS_CLK or posedge I_RST) begin
    if (I_RST) begin
      post_n_q <= '0;
    end else if (state_q == ATS_ST_IDLE) begin
      post_n_q <= '0;
    end else if (take && !pretrig_q) begin
      post_n_q <= post_n_q + CNT_W'(1);
    end
  end

  // ----------------------------------------
  // triggered scan counter
  // ----------------------------------------
  // a free prescaler gives the 20 MHz tick; the period reloads on expiry so pacing does not drift
  assign tick = div_q == '0;
  assign tsc_exp = tick && tsc_q == '0 && use_tsc && in_run;

  always_ff @(posedge I_SYS_CLK or posedge I_RST) begin
    if (I_RST) begin
      div_q <= '0;
    end else begin
      div_q <= (div_q == DIV_W'(`ATS_TSC_DIV - 1)) ? '0 : div_q + DIV_W'(1);
    end
  end

  always_ff @(posedge I_SYS_CLK or posedge I_RST) begin
    if (I_RST) begin
      tsc_q <= '0;
    end else if (!in_run || !use_tsc) begin
      tsc_q <= tscan_q;
    end else if (tick) begin
      tsc_q <= tsc_exp ? tscan_q : tsc_q - TSC_W'(1);
    end
  end

  // ----------------------------------------
  // outputs
  // ----------------------------------------
  always_ff @(posedge I_SYS_CLK or posedge I_RST) begin
    if (I_RST) begin
      O_TRIG_OUT <= 1'b0;
      O_CONVERT <= 1'b0;
      O_DISCARD <= 1'b0;
      O_PRETRIG <= 1'b0;
      O_CHAN_IDX <= '0;
      O_ACTIVE <= 1'b0;
    end else begin
      O_TRIG_OUT <= waiting;
      O_CONVERT <= take || pre_end;
      O_DISCARD <= pre_end;
      O_PRETRIG <= pretrig_q;
      O_CHAN_IDX <= chan_q;
      O_ACTIVE <= state_q != ATS_ST_IDLE;
    end
  end

  // ----------------------------------------
  // checks
  // ----------------------------------------
  default clocking cb @(posedge I_SYS_CLK); endclocking
  default disable iff (I_RST);

  a_sw_start_run: assert property (start_q && state_q == ATS_ST_IDLE && cfg_q.flow == ATS_FLOW_POST
    && cfg_q.src == ATS_SRC_SW && !stop_q |=> state_q == ATS_ST_ACQ ##1 !O_TRIG_OUT)
    else $error("software start did not begin acquisition");
  a_trig_out_wait: assert property (waiting && !stop_q |=> O_TRIG_OUT)
    else $error("trigger out low while waiting");
  a_chan_list_wrap: assert property (take && last_ch |=> chan_q == '0)
    else $error("channel index did not wrap after last entry");
  a_burst_to_wait: assert property (burst_end && !stop_q && !cnt_done |=> state_q == ATS_ST_RETRIG ##1 O_TRIG_OUT)
    else $error("burst end did not enter retrigger wait");
  a_retrig_resume: assert property (state_q == ATS_ST_RETRIG && retrig_ev && !stop_q && !pre_end
    |=> state_q == ATS_ST_ACQ)
    else $error("retrigger did not resume acquisition");
  a_burst_ignores: assert property (state_q == ATS_ST_ACQ && !samp && !stop_q && !pre_end
    |=> state_q == ATS_ST_ACQ && $stable(chan_q))
    else $error("burst disturbed without a sample");
  a_pre_end_stop: assert property (pre_end && !stop_q |=> state_q == ATS_ST_IDLE && O_DISCARD && O_CONVERT)
    else $error("post event did not end pre-trigger run");
  a_tsc_reload: assert property (tsc_exp |=> tsc_q == $past(tscan_q))
    else $error("scan counter did not reload on expiry");
  a_post_count_end: assert property (cnt_done && !stop_q |=> state_q == ATS_ST_IDLE ##1 !O_ACTIVE)
    else $error("post-trigger count reached but run continued");

  c_post_run: cover property (state_q == ATS_ST_WAIT ##1 state_q == ATS_ST_ACQ);
  c_retrig_burst: cover property (state_q == ATS_ST_RETRIG ##1 state_q == ATS_ST_ACQ);
  c_pre_end: cover property (pre_end);
  c_about_switch: cover property (cfg_q.flow == ATS_FLOW_ABOUT && pretrig_q ##1 !pretrig_q && in_run);
endmodule
`default_nettype wire

// ===== dv/ats_far_model.sv
// far-side model: trigger pin, sample clock and analog levels
`timescale 1ns/1ps
`default_nettype none
module ats_far_model (
  input wire logic i_clk,
  input wire logic i_rst,
  input wire logic i_trig_lvl,
  input wire logic [15:0] i_code,
  output logic o_ext_trig,
  output logic o_sample_clk,
  output logic [15:0] o_ext_analog,
  output logic [15:0] o_chan_analog
);
  logic [3:0] div_q;
  // free-running sample clock; 16 cycles a slot keeps the converter clear of overrun
  always_ff @(posedge i_clk or posedge i_rst) begin
    if (i_rst) begin
      div_q <= 4'h0;
    end else begin
      div_q <= div_q + 4'h1;
    end
  end
  assign o_sample_clk = div_q[3];
  // pins move only after an edge, never in the sampling instant
  always_ff @(posedge i_clk) begin
    o_ext_trig <= i_trig_lvl;
    o_ext_analog <= i_code;
  end
  // threshold channel is list entry 0 and shares one source type
  assign o_chan_analog = i_code;
endmodule
`default_nettype wire

// ===== dv/ats_sequencer_test.sv
// self-checking bench for the trigger sequencer
`timescale 1ns/1ps
`default_nettype none
`include "ats_defs.svh"
`define CHK(nm, e, g) begin tests_run++; if ((g) !== (e)) begin \
  $display("wrong value %s exp %h got %h", nm, e, g); n_mismatch++; end end
`define WAIT(c) begin n = 0; do begin @(posedge clk); n++; end while (!(c) && n < 400); lim(); end
module ats_sequencer_test;
  import ats_pkg::*;
  logic clk = 1'b0;
  logic rst = 1'b1;
  logic awv = 1'b0, wv = 1'b0, bry = 1'b0, arv = 1'b0, rry = 1'b0, trg = 1'b0;
  logic [7:0] awa = 8'h00, ara = 8'h00, thr;
  logic [31:0] wd = 32'h0, rdat, rdv;
  logic [15:0] code = 16'h0000, ea, ca;
  logic awr, wrd, bv, arr, rv, sck, tout, conv, disc, pre, act, xt;
  logic [1:0] br, rr, rrsp, wrsp;
  logic [9:0] chan;
  int n_mismatch = 0, tests_run = 0, n, k;
  always #5 clk = ~clk;
  ats_far_model far_u (.i_clk(clk), .i_rst(rst), .i_trig_lvl(trg), .i_code(code), .o_ext_trig(xt),
    .o_sample_clk(sck), .o_ext_analog(ea), .o_chan_analog(ca));
  ats_sequencer dut_u (.I_SYS_CLK(clk), .I_RST(rst), .I_AWVALID(awv), .O_AWREADY(awr), .I_AWADDR(awa),
    .I_WVALID(wv), .O_WREADY(wrd), .I_WDATA(wd), .I_WSTRB(4'hf), .O_BVALID(bv), .I_BREADY(bry),
    .O_BRESP(br), .I_ARVALID(arv), .O_ARREADY(arr), .I_ARADDR(ara), .O_RVALID(rv), .I_RREADY(rry),
    .O_RDATA(rdv), .O_RRESP(rr), .I_EXT_TRIG(xt), .I_SAMPLE_CLK(sck), .I_EXT_ANALOG(ea),
    .I_CHAN_ANALOG(ca), .O_THRESH_CODE(thr), .O_TRIG_OUT(tout), .O_CONVERT(conv), .O_DISCARD(disc),
    .O_PRETRIG(pre), .O_CHAN_IDX(chan), .O_ACTIVE(act));
  task automatic complete_run();
    if (n_mismatch == 0 && tests_run > 0) begin
      $display("TEST PASSED");
    end else begin
      $display("TEST FAILED");
    end
    $finish;
  endtask
  // a wait that ran out is a mismatch and ends the run
  task automatic lim();
    if (n >= 400) begin
      n_mismatch++;
      complete_run();
    end
  endtask
  task automatic wr(input logic [7:0] a, input logic [31:0] d);
    @(posedge clk);
    awv <= 1'b1;
    awa <= a;
    wv <= 1'b1;
    wd <= d;
    bry <= 1'b1;
    n = 0;
    do begin
      @(posedge clk);
      n++;
      if (awr) awv <= 1'b0;
      if (wrd) wv <= 1'b0;
    end while (!bv && n < 400);
    wrsp = br;
    bry <= 1'b0;
    lim();
  endtask
  task automatic rd(input logic [7:0] a);
    @(posedge clk);
    arv <= 1'b1;
    ara <= a;
    rry <= 1'b1;
    n = 0;
    do begin
      @(posedge clk);
      n++;
      if (arr) arv <= 1'b0;
    end while (!rv && n < 400);
    rdat = rdv;
    rrsp = rr;
    rry <= 1'b0;
    lim();
  endtask
  initial begin
    repeat (12) @(posedge clk);
    rst <= 1'b0;
    `CHK("trig out", 1'b0, tout)
    rd(`ATS_REG_CFG);
    `CHK("cfg", 32'h0, rdat)
    wr(`ATS_REG_THRESH, 32'h80);
    `CHK("wr okay", `ATS_RESP_OKAY, wrsp)
    rd(`ATS_REG_THRESH);
    `CHK("thresh", 32'h80, rdat)
    `CHK("thresh pin", 8'h80, thr)
    rd(8'h20);
    `CHK("unmapped", `ATS_RESP_SLVERR, rrsp)
    wr(8'h22, 32'h0);
    `CHK("wr unmapped", `ATS_RESP_SLVERR, wrsp)
    wr(`ATS_REG_CHLEN, 32'h2);
    // threshold start: one code short of the band must not fire
    wr(`ATS_REG_CFG, 32'h3);
    wr(`ATS_REG_CTRL, 32'h1);
    `WAIT(tout)
    code <= 16'h80a2;
    repeat (12) @(posedge clk);
    `CHK("hyst", 1'b1, tout)
    code <= 16'h80a3;
    for (int i = 0; i < 4; i++) begin
      `WAIT(conv)
      `CHK("chan", 10'(i % 3), chan)
    end
    wr(`ATS_REG_CTRL, 32'h2);
    `WAIT(!act)
    // falling threshold on the amplified channel; the level itself must not fire
    wr(`ATS_REG_CFG, 32'h404);
    wr(`ATS_REG_CTRL, 32'h1);
    `WAIT(tout)
    code <= 16'h8000;
    repeat (12) @(posedge clk);
    `CHK("hyst fall", 1'b1, tout)
    code <= 16'h7fff;
    `WAIT(conv)
    wr(`ATS_REG_CTRL, 32'h2);
    `WAIT(!act)
    wr(`ATS_REG_CFG, 32'h0);
    wr(`ATS_REG_POSTCNT, 32'h5);
    wr(`ATS_REG_CTRL, 32'h1);
    k = 0;
    repeat (200) @(posedge clk) k += int'(conv);
    `CHK("post count", 32'h5, k)
    `CHK("active", 1'b0, act)
    // external retrigger; an edge inside the burst must be lost
    wr(`ATS_REG_POSTCNT, 32'h0);
    wr(`ATS_REG_MSCAN, 32'h1);
    wr(`ATS_REG_CFG, 32'h301);
    wr(`ATS_REG_CTRL, 32'h1);
    `WAIT(tout)
    trg <= 1'b1;
    `WAIT(conv)
    trg <= 1'b0;
    repeat (4) @(posedge clk);
    trg <= 1'b1;
    k = 1;
    repeat (150) @(posedge clk) k += int'(conv);
    `CHK("burst", 32'h6, k)
    `CHK("wait retrig", 1'b1, tout)
    rd(`ATS_REG_STATUS);
    `CHK("status", 32'h28, rdat)
    trg <= 1'b0;
    repeat (4) @(posedge clk);
    trg <= 1'b1;
    `WAIT(conv)
    wr(`ATS_REG_CTRL, 32'h2);
    `WAIT(!act)
    trg <= 1'b0;
    // pre mode, software start, counter-paced bursts until the post event
    wr(`ATS_REG_MSCAN, 32'h0);
    wr(`ATS_REG_TSCAN, 32'h14);
    wr(`ATS_REG_CFG, 32'h111);
    wr(`ATS_REG_CTRL, 32'h1);
    `WAIT(conv)
    `CHK("pretrig", 1'b1, pre)
    k = 1;
    repeat (300) @(posedge clk) k += int'(conv);
    `CHK("pre bursts", 1'b1, k > 3)
    trg <= 1'b1;
    `WAIT(disc)
    `CHK("discard", 1'b1, conv)
    `WAIT(!act)
    // falling external edge as start, then about mode switching to post data
    wr(`ATS_REG_CFG, 32'h2);
    wr(`ATS_REG_CTRL, 32'h1);
    `WAIT(tout)
    trg <= 1'b0;
    `WAIT(conv)
    wr(`ATS_REG_CTRL, 32'h2);
    `WAIT(!act)
    wr(`ATS_REG_POSTCNT, 32'h2);
    wr(`ATS_REG_CFG, 32'h21);
    wr(`ATS_REG_CTRL, 32'h1);
    `WAIT(conv)
    `CHK("about pre", 1'b1, pre)
    trg <= 1'b1;
    `WAIT(!act)
    complete_run();
  end
endmodule
`default_nettype wire
